//--- bench/mmd_decoder_props.sv
// Port assertions of the memory map decoder
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_props
(
    // Clock, reset, processor bus
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_req,
    input wire logic        cpu_we,
    input wire logic        cpu_fetch,
    input wire logic [15:0] cpu_rdata,
    input wire logic        cpu_ready,
    input wire logic [15:0] cpu_boot_addr,
    input wire logic        cpu_boot_valid,
    // Settings, selects, USB port
    input wire logic        xrom_low_en,
    input wire logic [1:0]  xwin_en,
    input wire logic        ext_rom_select_n,
    input wire logic        int_rom_select,
    input wire logic        int_ram_select,
    input wire logic [1:0]  ram_zone,
    input wire logic        usb_serial_engine_req,
    input wire logic        usb_serial_engine_grant
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_boot_take; cpu_req && cpu_fetch && cpu_addr == 16'hfff0; endsequence
    sequence s_jump_rd; cpu_req && !cpu_we && cpu_addr inside {[16'hfff1:16'hfff3]}; endsequence
    property p_rom;
        cpu_req && cpu_addr >= 16'he800 |-> int_rom_select && !int_ram_select && ext_rom_select_n;
    endproperty
    property p_none;
        cpu_req && xwin_en == 2'b00 && cpu_addr inside {[16'h0e00:16'h7fff]}
        |-> ext_rom_select_n && !int_rom_select && !int_ram_select;
    endproperty
    property p_boot; s_boot_take |=> !cpu_boot_valid; endproperty
    property p_bvec; cpu_boot_valid |-> cpu_boot_addr == 16'hfff0; endproperty
    property p_jump; s_jump_rd |=> cpu_ready && cpu_rdata == 16'he800; endproperty
    property p_xdef; cpu_req && cpu_addr inside {[16'hc100:16'he7ff]} |-> !ext_rom_select_n; endproperty
    property p_xlow;
        cpu_req && xrom_low_en && cpu_addr inside {[16'h8000:16'hc0ff]} |-> !ext_rom_select_n;
    endproperty
    property p_ram; cpu_req && cpu_addr <= 16'h0dff |-> int_ram_select ##1 cpu_ready; endproperty
    property p_usb; cpu_req && int_ram_select && usb_serial_engine_req |=> !usb_serial_engine_grant;
    endproperty
    property p_vec; cpu_req && cpu_addr <= 16'h00ff |-> ram_zone == 2'b01; endproperty
    property p_bank; cpu_req && cpu_addr inside {[16'h0100:16'h01ff]} |-> ram_zone == 2'b11; endproperty
    property p_istk; cpu_req && cpu_addr inside {[16'h0200:16'h021f]} |-> ram_zone == 2'b10; endproperty
    a_rom: assert property (p_rom) else $error("rom select wrong");
    a_none: assert property (p_none) else $error("select on unmapped address");
    a_boot: assert property (p_boot) else $error("boot flag stuck");
    a_bvec: assert property (p_bvec) else $error("boot address wrong");
    a_jump: assert property (p_jump) else $error("jump word wrong");
    a_xdef: assert property (p_xdef) else $error("default window missed");
    a_xlow: assert property (p_xlow) else $error("low window missed");
    a_ram: assert property (p_ram) else $error("ram select or ready wrong");
    a_usb: assert property (p_usb) else $error("usb granted over cpu");
    a_vec: assert property (p_vec) else $error("vector zone wrong");
    a_bank: assert property (p_bank) else $error("bank zone wrong");
    a_istk: assert property (p_istk) else $error("stack zone wrong");
endmodule
`default_nettype wire

//--- bench/mmd_rom_array.sv
// Mask ROM array model behind the decoder's ROM port
`timescale 1ns/10ps
`default_nettype none
module mmd_rom_array
(
    // Array port
    input  wire logic [15:0] rom_addr,
    output logic      [15:0] rom_data
);
    // Address-derived content, so a wrong word shows up
    assign rom_data = rom_addr ^ 16'ha55a;
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking testbench of the memory map decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mmd_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, cpu_fetch = 1'b0;
    logic        xrom_low_en = 1'b0, u_req = 1'b0, u_we = 1'b0, u_grant, cpu_ready, cpu_boot_valid;
    logic        ext_rom_select_n, int_rom_select, int_ram_select;
    logic [15:0] cpu_addr = 16'h0, cpu_wdata = 16'h0, u_wdata = 16'h0, rom_addr, rom_data, d, a;
    logic [15:0] cpu_rdata, cpu_boot_addr, u_rdata;
    logic [15:0] xwin_base [2] = '{16'h1000, 16'h3000};
    logic [15:0] xwin_end  [2] = '{16'h1fff, 16'h30ff};
    logic [15:0] edges     [12] = '{16'h0, 16'h0dff, 16'h0e00, 16'h7fff, 16'h8000, 16'hc0ff,
                                    16'hc100, 16'he7ff, 16'h1fff, 16'h2000, 16'h30ff, 16'h1000};
    logic [15:0] zaddr     [4] = '{16'h0010, 16'h01f0, 16'h021f, 16'h0dff};
    logic [1:0]  xwin_en = 2'b00, ram_zone;
    logic [10:0] u_addr = 11'h0;
    logic [16:0] n;
    logic [16:0] notes [$];
    int          miscompares = 0, cmp_count = 0, seed = 36720, i;

    mmd_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_fetch(cpu_fetch), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_ready(cpu_ready), .cpu_boot_addr(cpu_boot_addr), .cpu_boot_valid(cpu_boot_valid),
        .xrom_low_en(xrom_low_en), .xwin_en(xwin_en), .xwin_base(xwin_base), .xwin_end(xwin_end),
        .ext_rom_select_n(ext_rom_select_n), .int_rom_select(int_rom_select),
        .int_ram_select(int_ram_select), .ram_zone(ram_zone), .rom_addr(rom_addr),
        .rom_data(rom_data), .usb_serial_engine_req(u_req), .usb_serial_engine_we(u_we),
        .usb_serial_engine_addr(u_addr), .usb_serial_engine_wdata(u_wdata),
        .usb_serial_engine_rdata(u_rdata), .usb_serial_engine_grant(u_grant));
    mmd_rom_array u_rom (.rom_addr(rom_addr), .rom_data(rom_data));

    always #20 core_clk = ~core_clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Expected selects {ext_n, rom, ram}; ROM wins the shared 0xe800 boundary
    function automatic logic [2:0] sel_of(input logic [15:0] x);
        return x <= 16'h0dff ? 3'b101 : x >= 16'he800 ? 3'b110 :
            (x >= 16'hc100 || (xrom_low_en && x >= 16'h8000) ||
             (xwin_en[0] && x inside {[16'h1000:16'h1fff]}) ||
             (xwin_en[1] && x inside {[16'h3000:16'h30ff]})) ? 3'b000 : 3'b100;
    endfunction

    function automatic logic [1:0] zone_of(input logic [15:0] x);
        return x > 16'h0dff ? 2'b00 : x <= 16'h00ff ? 2'b01 : x <= 16'h01ff ? 2'b11 :
            x <= 16'h021f ? 2'b10 : 2'b00;
    endfunction

    function automatic logic [15:0] top_of(input int k);
        return k == 0 ? LJMP_OPCODE : k < 4 ? 16'he800 : k < 10 ? RSVD_WORD : k < 12 ? CHECKSUM :
            k < 14 ? FW_REVISION : k == 14 ? {8'h00, PERIPH_REV} : {8'h00, ISA_REV};
    endfunction

    // One request cycle; read notes carry bit 16 set when data is compared
    task automatic cpu(input logic [15:0] x, input logic we, input logic [16:0] note);
        cpu_addr = x;
        cpu_we = we;
        cpu_wdata = note[15:0];
        cpu_req = 1'b1;
        #2;
        check("selects", {13'h0, ext_rom_select_n, int_rom_select, int_ram_select},
              {13'h0, sel_of(x)});
        check("ram zone", {14'h0, ram_zone}, {14'h0, zone_of(x)});
        if (sel_of(x) != 3'b100 && sel_of(x) != 3'b000)
            notes.push_back(we ? 17'h0 : note);
        @(posedge core_clk);
        #1;
    endtask

    // Released address shows the inverse, not a stale value
    task automatic idle;
        cpu_req = 1'b0;
        cpu_addr = ~cpu_addr;
        @(posedge core_clk);
        #1;
    endtask

    always @(negedge core_clk)
        if (rst_n && cpu_ready === 1'b1)
        begin
            n = notes.size() > 0 ? notes.pop_front() : 17'h1ffff;
            if (n === 17'h1ffff)
                check("ready without request", 16'h1, 16'h0);
            else if (n[16])
                check("read data", cpu_rdata, n[15:0]);
        end

    initial
    begin
        #(40 * 4000);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (10) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        check("boot valid", {15'h0, cpu_boot_valid}, 16'h1);
        check("boot addr", cpu_boot_addr, BOOT_VECTOR);
        cpu_fetch = 1'b1;
        cpu(BOOT_VECTOR, 1'b0, {1'b1, top_of(0)});
        cpu_fetch = 1'b0;
        check("boot valid", {15'h0, cpu_boot_valid}, 16'h0);
        for (i = 1; i < 16; i++)
            cpu(16'hfff0 + 16'(i), 1'b0, {1'b1, top_of(i)});
        cpu(ROM_BASE, 1'b0, {1'b1, ROM_BASE ^ 16'ha55a});
        idle();
        $display("boot and rom test done");
        for (i = 0; i < 60; i++)
        begin
            xrom_low_en = i[0];
            xwin_en = i[2:1];
            a = i < 24 ? edges[i / 2] : 16'($random(seed));
            cpu(a, 1'b0, 17'h0);
            idle();
        end
        $display("decode sweep test done");
        for (i = 0; i < 4; i++)
        begin
            d = 16'($random(seed));
            cpu(zaddr[i], 1'b1, {1'b0, d});
            cpu(zaddr[i], 1'b0, {1'b1, d});
        end
        idle();
        u_addr = 11'h020;
        u_wdata = d;
        u_we = 1'b1;
        u_req = 1'b1;
        @(posedge core_clk);
        #1;
        u_req = 1'b0;
        check("usb grant", {15'h0, u_grant}, 16'h1);
        cpu(16'h0020, 1'b0, {1'b1, d});
        u_addr = 11'h030;
        u_wdata = ~d;
        u_req = 1'b1;
        cpu(16'h0030, 1'b1, {1'b0, d});
        u_req = 1'b0;
        check("usb refused", {15'h0, u_grant}, 16'h0);
        idle();
        u_we = 1'b0;
        u_req = 1'b1;
        @(posedge core_clk);
        #1;
        u_req = 1'b0;
        check("usb read", u_rdata, d);
        $display("shared ram test done");
        rst_n = 1'b0;
        #80;
        check("boot after reset", {15'h0, cpu_boot_valid}, 16'h1);
        rst_n = 1'b1;
        cpu_fetch = 1'b1;
        cpu(BOOT_VECTOR, 1'b0, {1'b1, top_of(0)});
        cpu_fetch = 1'b0;
        check("boot after fetch", {15'h0, cpu_boot_valid}, 16'h0);
        idle();
        check("pending answers", 16'(notes.size()), 16'h0);
        $display("reset test done");
        report_and_stop();
    end
endmodule

bind mmd_decoder mmd_decoder_props u_props (.core_clk, .rst_n, .cpu_addr, .cpu_req, .cpu_we,
    .cpu_fetch, .cpu_rdata, .cpu_ready, .cpu_boot_addr, .cpu_boot_valid, .xrom_low_en, .xwin_en,
    .ext_rom_select_n, .int_rom_select, .int_ram_select, .ram_zone, .usb_serial_engine_req,
    .usb_serial_engine_grant);
`default_nettype wire

//--- rtl/mmd_decoder.sv
// Processor memory map decoder, boot steering and shared RAM arbitration
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder
(
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    // Processor bus
    input  wire logic [mmd_pkg::ADDR_W-1:0]      cpu_addr,
    input  wire logic                            cpu_req,
    input  wire logic                            cpu_we,
    input  wire logic                            cpu_fetch,
    input  wire logic [mmd_pkg::DATA_W-1:0]      cpu_wdata,
    output logic      [mmd_pkg::DATA_W-1:0]      cpu_rdata,
    output logic                                 cpu_ready,
    output logic      [mmd_pkg::ADDR_W-1:0]      cpu_boot_addr,
    output logic                                 cpu_boot_valid,
    // External ROM window settings
    input  wire logic                            xrom_low_en,
    input  wire logic [mmd_pkg::NUM_WIN-1:0]     xwin_en,
    input  wire logic [mmd_pkg::ADDR_W-1:0]      xwin_base [mmd_pkg::NUM_WIN],
    input  wire logic [mmd_pkg::ADDR_W-1:0]      xwin_end  [mmd_pkg::NUM_WIN],
    // Memory selects
    output logic                                 ext_rom_select_n,
    output logic                                 int_rom_select,
    output logic                                 int_ram_select,
    output logic      [1:0]                      ram_zone,
    // Mask ROM array port
    output logic      [mmd_pkg::ADDR_W-1:0]      rom_addr,
    input  wire logic [mmd_pkg::DATA_W-1:0]      rom_data,
    // USB serial engine RAM port
    input  wire logic                            usb_serial_engine_req,
    input  wire logic                            usb_serial_engine_we,
    input  wire logic [mmd_pkg::RAM_AW-1:0]      usb_serial_engine_addr,
    input  wire logic [mmd_pkg::DATA_W-1:0]      usb_serial_engine_wdata,
    output logic      [mmd_pkg::DATA_W-1:0]      usb_serial_engine_rdata,
    output logic                                 usb_serial_engine_grant
);
    import mmd_pkg::*;

    // Decode
    mmd_sel_t                   sel;
    logic                       rom_hit;
    logic                       ram_hit;
    logic                       ext_hit;
    logic                       top_hit;
    logic [DATA_W-1:0]          top_word;

    // Boot steering
    mmd_boot_t                  boot;
    mmd_boot_t                  next_boot;
    logic                       boot_take;

    // Shared RAM and answers
    logic [DATA_W-1:0]          ram [RAM_WORDS];
    logic [DATA_W-1:0]          next_cpu_rdata;
    logic                       next_cpu_ready;
    logic [DATA_W-1:0]          next_usb_rdata;
    logic                       next_grant;
    logic                       cpu_ram;
    logic                       usb_in_range;
    logic                       usb_ok;
    logic [RAM_AW-1:0]          cpu_idx;
    logic                       ram_we;
    logic [RAM_AW-1:0]          ram_widx;
    logic [DATA_W-1:0]          ram_wdata;

    // Internal regions are fixed by the map
    assign rom_hit = mmd_in(cpu_addr, ROM_BASE, ROM_TOP);
    assign ram_hit = mmd_in(cpu_addr, RAM_BASE, RAM_END);

    // Window decode, internal regions first
    always_comb
    begin
        ext_hit = mmd_in(cpu_addr, XROM_BASE, XROM_END)
                  || (xrom_low_en && mmd_in(cpu_addr, XLOW_BASE, XLOW_END));
        for (int i = 0; i < NUM_WIN; i++)
        begin
            if (xwin_en[i] && mmd_in(cpu_addr, xwin_base[i], xwin_end[i]))
                ext_hit = 1'b1;
        end
        // End of default window overlaps ROM base; internal ROM wins
        if (rom_hit)
            sel = MMD_SEL_ROM;
        else if (ram_hit)
            sel = MMD_SEL_RAM;
        else if (ext_hit)
            sel = MMD_SEL_XROM;
        else
            sel = MMD_SEL_NONE;
    end

    assign ext_rom_select_n = !(cpu_req && sel == MMD_SEL_XROM);
    assign int_rom_select   = cpu_req && sel == MMD_SEL_ROM;
    assign int_ram_select   = cpu_req && sel == MMD_SEL_RAM;
    assign rom_addr         = cpu_addr;

    // RAM zones for the core's vector, bank and stack logic
    always_comb
    begin
        if (sel != MMD_SEL_RAM)
            ram_zone = MMD_RAM_OTHER;
        else if (mmd_in(cpu_addr, RAM_BASE, VEC_END))
            ram_zone = MMD_RAM_VEC;
        else if (mmd_in(cpu_addr, BANK_BASE, BANK_END))
            ram_zone = MMD_RAM_BANK;
        else if (mmd_in(cpu_addr, ISTK_BASE, ISTK_END))
            ram_zone = MMD_RAM_ISTK;
        else
            ram_zone = MMD_RAM_OTHER;
    end

    // Fixed words override the array at the top of ROM
    mmd_rom_top u_rom_top
    (
        .addr (cpu_addr),
        .word (top_word),
        .hit  (top_hit)
    );

    // Boot steering: the vector stays valid after reset until a fetch from it is taken
    assign boot_take = cpu_req && cpu_fetch && cpu_addr == BOOT_VECTOR;

    always_comb
    begin
        next_boot = boot;
        unique case (boot)
            MMD_BOOT_RESET: next_boot = MMD_BOOT_FETCH;
            MMD_BOOT_FETCH:
                if (boot_take)
                    next_boot = MMD_BOOT_RUN;
            MMD_BOOT_RUN:   next_boot = MMD_BOOT_RUN;
            default:        next_boot = MMD_BOOT_RESET;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        // Reset lands in the fetch wait, so a fetch on the first edge counts
        if (!rst_n)
            boot <= MMD_BOOT_FETCH;
        else
            boot <= next_boot;
    end

    assign cpu_boot_addr  = BOOT_VECTOR;
    assign cpu_boot_valid = boot != MMD_BOOT_RUN;

    // Shared RAM: processor has priority, engine request is refused in that cycle and not held
    // Only the low index reaches the array
    assign cpu_idx      = cpu_addr[RAM_AW-1:0];
    assign cpu_ram      = int_ram_select;
    // Indexes past the array are refused rather than aliased
    assign usb_in_range = usb_serial_engine_addr < RAM_AW'(RAM_WORDS);
    assign usb_ok       = usb_serial_engine_req && !cpu_ram && usb_in_range;

    always_comb
    begin
        next_cpu_rdata = '0;
        next_usb_rdata = usb_serial_engine_rdata;
        next_grant     = usb_ok;
        // External and unmapped cycles are answered by other logic
        next_cpu_ready = cpu_req && (sel == MMD_SEL_ROM || sel == MMD_SEL_RAM);
        if (cpu_req && !cpu_we)
        begin
            unique case (sel)
                MMD_SEL_ROM:  next_cpu_rdata = top_hit ? top_word : rom_data;
                MMD_SEL_RAM:  next_cpu_rdata = ram[cpu_idx];
                MMD_SEL_XROM: next_cpu_rdata = '0;
                MMD_SEL_NONE: next_cpu_rdata = '0;
            endcase
        end
        if (usb_ok && !usb_serial_engine_we)
            next_usb_rdata = ram[usb_serial_engine_addr];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_rdata               <= '0;
            cpu_ready               <= 1'b0;
            usb_serial_engine_rdata <= '0;
            usb_serial_engine_grant <= 1'b0;
        end
        else
        begin
            cpu_rdata               <= next_cpu_rdata;
            cpu_ready               <= next_cpu_ready;
            usb_serial_engine_rdata <= next_usb_rdata;
            usb_serial_engine_grant <= next_grant;
        end
    end

    // One write port; a processor write beats the engine in the same cycle
    always_comb
    begin
        ram_we    = 1'b0;
        ram_widx  = cpu_idx;
        ram_wdata = cpu_wdata;
        if (cpu_ram && cpu_we)
            ram_we = 1'b1;
        else if (usb_ok && usb_serial_engine_we)
        begin
            ram_we    = 1'b1;
            ram_widx  = usb_serial_engine_addr;
            ram_wdata = usb_serial_engine_wdata;
        end
    end

    // Storage carries no reset; contents are undefined after power-up
    always_ff @(posedge core_clk)
    begin
        if (ram_we)
            ram[ram_widx] <= ram_wdata;
    end
endmodule
`default_nettype wire

//--- rtl/mmd_rom_top.sv
// Fixed boot words at the top of the internal ROM
`timescale 1ns/10ps
`default_nettype none
module mmd_rom_top
(
    // Word address and content
    input  wire logic [mmd_pkg::ADDR_W-1:0] addr,
    output logic      [mmd_pkg::DATA_W-1:0] word,
    output logic                            hit
);
    import mmd_pkg::*;

    always_comb
    begin
        hit  = 1'b1;
        word = RSVD_WORD;
        if (addr == BOOT_VECTOR)
            word = LJMP_OPCODE;
        else if (mmd_in(addr, BOOT_VECTOR, JUMP_END))
            word = ROM_BASE;
        else if (mmd_in(addr, RSVD_BASE, RSVD_END))
            word = RSVD_WORD;
        else if (mmd_in(addr, CSUM_LO, CSUM_HI))
            word = CHECKSUM;
        else if (mmd_in(addr, FWREV_LO, FWREV_HI))
            word = FW_REVISION;
        else if (addr == PERREV_ADDR)
            word = {8'h00, PERIPH_REV};
        else if (addr == ISAREV_ADDR)
            word = {8'h00, ISA_REV};
        else
            hit = 1'b0;
    end
endmodule
`default_nettype wire

//--- shared/mmd_pkg.sv
// Constants of the processor memory map decoder
`default_nettype none
package mmd_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 16;
    localparam int          RAM_AW         = 11;
    localparam int          RAM_WORDS      = 1536;
    localparam int          NUM_WIN        = 2;
    localparam logic [15:0] ROM_BASE       = 16'he800;
    localparam logic [15:0] ROM_TOP        = 16'hffff;
    localparam logic [15:0] BOOT_VECTOR    = 16'hfff0;
    localparam logic [15:0] JUMP_END       = 16'hfff3;
    localparam logic [15:0] RSVD_BASE      = 16'hfff4;
    localparam logic [15:0] RSVD_END       = 16'hfff9;
    localparam logic [15:0] CSUM_LO        = 16'hfffa;
    localparam logic [15:0] CSUM_HI        = 16'hfffb;
    localparam logic [15:0] FWREV_LO       = 16'hfffc;
    localparam logic [15:0] FWREV_HI       = 16'hfffd;
    localparam logic [15:0] PERREV_ADDR    = 16'hfffe;
    localparam logic [15:0] ISAREV_ADDR    = 16'hffff;
    localparam logic [15:0] XROM_BASE      = 16'hc100;
    localparam logic [15:0] XROM_END       = 16'he800;
    localparam logic [15:0] XLOW_BASE      = 16'h8000;
    localparam logic [15:0] XLOW_END       = 16'hc100;
    localparam logic [15:0] RAM_BASE       = 16'h0000;
    localparam logic [15:0] RAM_END        = 16'h0dff;
    localparam logic [15:0] VEC_END        = 16'h00ff;
    localparam logic [15:0] BANK_BASE      = 16'h0100;
    localparam logic [15:0] BANK_END       = 16'h01ff;
    localparam logic [15:0] ISTK_BASE      = 16'h0200;
    localparam logic [15:0] ISTK_END       = 16'h021f;
    localparam logic [15:0] LJMP_OPCODE    = 16'h0000;
    localparam logic [15:0] RSVD_WORD      = 16'h0000;
    localparam logic [15:0] CHECKSUM       = 16'h0000;
    localparam logic [15:0] FW_REVISION    = 16'h0001;
    localparam logic [7:0]  PERIPH_REV     = 8'h01;
    localparam logic [7:0]  ISA_REV        = 8'h01;

    typedef enum logic [1:0] {
        MMD_SEL_NONE = 2'b00,
        MMD_SEL_RAM  = 2'b01,
        MMD_SEL_ROM  = 2'b11,
        MMD_SEL_XROM = 2'b10
    } mmd_sel_t;

    typedef enum logic [1:0] {
        MMD_RAM_OTHER = 2'b00,
        MMD_RAM_VEC   = 2'b01,
        MMD_RAM_BANK  = 2'b11,
        MMD_RAM_ISTK  = 2'b10
    } mmd_ramzone_t;

    typedef enum logic [1:0] {
        MMD_BOOT_RESET = 2'b00,
        MMD_BOOT_FETCH = 2'b01,
        MMD_BOOT_RUN   = 2'b11
    } mmd_boot_t;

    function automatic logic mmd_in(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction
endpackage
`default_nettype wire
